// ===== core/serial_mem_pkg.sv
// Shared constants and types for the two-wire serial memory link
package serial_mem_pkg;
	// Device type identifiers and reserved host codes
	localparam logic [3:0] TYPE_ARRAY = 4'hA;
	localparam logic [3:0] TYPE_REGS = 4'hB;
	localparam logic [6:0] CODE_MFG_ID = 7'h7C;
	localparam logic [4:0] CODE_HS_MODE = 5'h01;
	// First word address byte field positions
	localparam int WA_TOP_POS = 7;
	localparam int WA_SEL_HI = 3;
	localparam int WA_SEL_LO = 2;
	localparam logic [1:0] WA_SEL_REG = 2'h2;
	localparam logic [3:0] WA_LOCK_CODE = 4'h6;
	// Bits per byte and recovery clocks
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] RECOVERY_CLOCKS = 4'h9;
	// Host link clock: quarter period (one sequencer phase) in ns and in system clocks
	localparam int MCLK_NS = 40;
	localparam int LINK_HALF_NS = 160;
	localparam int LINK_HALF_CYC = (LINK_HALF_NS + MCLK_NS - 1) / MCLK_NS;
	localparam logic [3:0] LINK_HALF_CNT = 4'(LINK_HALF_CYC);
	// Decoded access target
	typedef enum logic [2:0] {
		TGT_NONE,
		TGT_ARRAY,
		TGT_SECURITY,
		TGT_CONFIG,
		TGT_LOCK,
		TGT_MFG_ID,
		TGT_HS_MODE
	} target_t;
endpackage

// ===== core/two_wire_if.sv
// Two-wire bus interface joining the host and the memory client
`timescale 1ns/1ps
interface two_wire_if;
	logic scl_o;
	logic scl_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic scl;
	logic sda;
	// Open-drain wired-and with pull-up
	assign scl = scl_oe ? scl_o : 1'b1;
	assign sda = (sda_host_oe ? sda_host_o : 1'b1) &
		(sda_dev_oe ? sda_dev_o : 1'b1);
	modport host (output scl_o, output scl_oe, output sda_host_o,
		output sda_host_oe, input scl, input sda);
	modport device (output sda_dev_o, output sda_dev_oe, input scl,
		input sda);
endinterface

// ===== core/serial_mem_client.sv
// Memory client end: framing, address decode and acknowledge
`timescale 1ns/1ps
module serial_mem_client
(
	input wire logic mclk_i,
	input wire logic reset_i,
	two_wire_if.device bus,
	input wire logic [2:0] hw_select_i,
	input wire logic write_busy_i,
	input wire logic [7:0] read_data_i,
	output logic selected_o,
	output logic read_mode_o,
	output serial_mem_pkg::target_t target_o,
	output logic [15:0] word_addr_o,
	output logic addr_valid_o,
	output logic [7:0] wr_data_o,
	output logic wr_data_valid_o,
	output logic read_next_o,
	output logic standby_o
);
	import serial_mem_pkg::*;

	typedef enum {
		ST_IDLE,
		ST_DEV_ADDR,
		ST_WORD_HI,
		ST_WORD_LO,
		ST_WRITE_DATA,
		ST_READ_DATA
	} phase_t;

	////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers for the pins
	logic scl_s1_reg, scl_s2_reg, scl_d_reg;
	logic sda_s1_reg, sda_s2_reg, sda_d_reg;
	logic [2:0] sel_s1_reg, sel_s2_reg;
	always_ff @(posedge mclk_i)
	begin
		scl_s1_reg <= bus.scl;
		scl_s2_reg <= scl_s1_reg;
		scl_d_reg <= scl_s2_reg;
		sda_s1_reg <= bus.sda;
		sda_s2_reg <= sda_s1_reg;
		sda_d_reg <= sda_s2_reg;
		// Select straps are pins too, so they get the same two stages
		sel_s1_reg <= hw_select_i;
		sel_s2_reg <= sel_s1_reg;
	end

	// Edge and condition detection on synchronised levels
	logic scl_rise, scl_fall, start_cond, stop_cond;
	assign scl_rise = scl_s2_reg & ~scl_d_reg;
	assign scl_fall = ~scl_s2_reg & scl_d_reg;
	assign start_cond = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
	assign stop_cond = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

	// Address byte decode, returns TGT_NONE on any mismatch
	function automatic target_t decode_dev(input logic [7:0] b,
		input logic [2:0] sel);
		target_t t;
		t = TGT_NONE;
		if (b[7:1] == CODE_MFG_ID)
			t = TGT_MFG_ID;
		else if (b[7:3] == CODE_HS_MODE)
			t = TGT_HS_MODE;
		else if (b[3:1] == sel)
		begin
			if (b[7:4] == TYPE_ARRAY)
				t = TGT_ARRAY;
			else if (b[7:4] == TYPE_REGS)
				t = TGT_SECURITY;
		end
		return t;
	endfunction

	// Register target refined by the first word address byte
	function automatic target_t decode_word(input logic [7:0] b);
		target_t t;
		t = TGT_NONE;
		if (b[3:0] == WA_LOCK_CODE)
			t = TGT_LOCK;
		else if (b[WA_SEL_HI:WA_SEL_LO] == WA_SEL_REG)
			t = b[WA_TOP_POS] ? TGT_CONFIG : TGT_SECURITY;
		return t;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Protocol state
	phase_t phase_reg, phase_next;
	logic [7:0] shift_reg, shift_next;
	logic [3:0] bit_cnt_reg, bit_cnt_next;
	logic ack_slot_reg, ack_slot_next;
	logic drive_low_reg, drive_low_next;
	logic ack_pend_reg, ack_pend_next;
	logic sel_reg, sel_next;
	logic rd_reg, rd_next;
	target_t tgt_reg, tgt_next;
	logic [15:0] waddr_reg, waddr_next;
	logic av_reg, av_next;
	logic [7:0] wd_reg, wd_next;
	logic wdv_reg, wdv_next;
	logic rn_reg, rn_next;
	logic standby_reg, standby_next;

	always_comb
	begin
		phase_next = phase_reg;
		shift_next = shift_reg;
		bit_cnt_next = bit_cnt_reg;
		ack_slot_next = ack_slot_reg;
		drive_low_next = drive_low_reg;
		ack_pend_next = ack_pend_reg;
		sel_next = sel_reg;
		rd_next = rd_reg;
		tgt_next = tgt_reg;
		waddr_next = waddr_reg;
		av_next = 1'b0;
		wd_next = wd_reg;
		wdv_next = 1'b0;
		rn_next = 1'b0;
		if (start_cond)
		begin
			// Restart framing, even mid byte
			phase_next = ST_DEV_ADDR;
			bit_cnt_next = 4'h0;
			ack_slot_next = 1'b0;
			drive_low_next = 1'b0;
			sel_next = 1'b0;
		end
		else if (stop_cond)
		begin
			phase_next = ST_IDLE;
			drive_low_next = 1'b0;
			ack_slot_next = 1'b0;
			sel_next = 1'b0;
		end
		else if (phase_reg != ST_IDLE && scl_rise && !ack_slot_reg)
		begin
			// Sample data during clock high, MSB first
			shift_next = {shift_reg[6:0], sda_s2_reg};
			bit_cnt_next = bit_cnt_reg + 4'h1;
		end
		else if (phase_reg != ST_IDLE && scl_rise && ack_slot_reg
			&& phase_reg == ST_READ_DATA && sda_s2_reg)
		begin
			// Host nack ends the read
			phase_next = ST_IDLE;
			sel_next = 1'b0;
		end
		else if (phase_reg != ST_IDLE && scl_fall)
		begin
			drive_low_next = 1'b0;
			if (ack_slot_reg)
			begin
				ack_slot_next = 1'b0;
				bit_cnt_next = 4'h0;
				if (phase_reg == ST_READ_DATA)
				begin
					drive_low_next = ~read_data_i[7];
					rn_next = 1'b1;
				end
			end
			else if (phase_reg == ST_READ_DATA)
			begin
				if (bit_cnt_reg == BITS_PER_BYTE)
					ack_slot_next = 1'b1;
				else
					drive_low_next = ~read_data_i[3'(7 - bit_cnt_reg)];
			end
			else if (bit_cnt_reg == BITS_PER_BYTE)
			begin
				ack_slot_next = 1'b1;
				ack_pend_next = 1'b1;
				unique case (phase_reg)
					ST_DEV_ADDR:
					begin
						tgt_next = decode_dev(shift_reg, sel_s2_reg);
						rd_next = shift_reg[0];
						// Busy or mismatch: silent and back to standby
						if (write_busy_i || decode_dev(shift_reg,
							sel_s2_reg) == TGT_NONE)
						begin
							ack_pend_next = 1'b0;
							phase_next = ST_IDLE;
						end
						else
						begin
							sel_next = 1'b1;
							if (decode_dev(shift_reg, sel_s2_reg)
								== TGT_HS_MODE)
							begin
								ack_pend_next = 1'b0;
								phase_next = ST_IDLE;
							end
							else if (shift_reg[0])
								phase_next = ST_READ_DATA;
							else
								phase_next = ST_WORD_HI;
						end
					end
					ST_WORD_HI:
					begin
						waddr_next[15:8] = shift_reg;
						if (tgt_reg != TGT_ARRAY)
							tgt_next = decode_word(shift_reg);
						phase_next = ST_WORD_LO;
					end
					ST_WORD_LO:
					begin
						waddr_next[7:0] = shift_reg;
						av_next = 1'b1;
						phase_next = ST_WRITE_DATA;
					end
					ST_WRITE_DATA:
					begin
						wd_next = shift_reg;
						wdv_next = 1'b1;
					end
					default:
						phase_next = ST_IDLE;
				endcase
				drive_low_next = ack_pend_next;
			end
		end
		else if (!ack_slot_reg)
			ack_pend_next = 1'b0;
		standby_next = (phase_next == ST_IDLE);
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			phase_reg <= ST_IDLE;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
			ack_slot_reg <= 1'b0;
			drive_low_reg <= 1'b0;
			ack_pend_reg <= 1'b0;
			sel_reg <= 1'b0;
			rd_reg <= 1'b0;
			tgt_reg <= TGT_NONE;
			waddr_reg <= 16'h0000;
			av_reg <= 1'b0;
			wd_reg <= 8'h00;
			wdv_reg <= 1'b0;
			rn_reg <= 1'b0;
			standby_reg <= 1'b1;
		end
		else
		begin
			phase_reg <= phase_next;
			shift_reg <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
			ack_slot_reg <= ack_slot_next;
			drive_low_reg <= drive_low_next;
			ack_pend_reg <= ack_pend_next;
			sel_reg <= sel_next;
			rd_reg <= rd_next;
			tgt_reg <= tgt_next;
			waddr_reg <= waddr_next;
			av_reg <= av_next;
			wd_reg <= wd_next;
			wdv_reg <= wdv_next;
			rn_reg <= rn_next;
			standby_reg <= standby_next;
		end
	end

	// Open drain: only ever pull low, reset releases the line
	assign bus.sda_dev_o = 1'b0;
	assign bus.sda_dev_oe = drive_low_reg;
	assign selected_o = sel_reg;
	assign read_mode_o = rd_reg;
	assign target_o = tgt_reg;
	assign word_addr_o = waddr_reg;
	assign addr_valid_o = av_reg;
	assign wr_data_o = wd_reg;
	assign wr_data_valid_o = wdv_reg;
	assign read_next_o = rn_reg;
	assign standby_o = standby_reg;
endmodule

// ===== core/serial_mem_host.sv
// Host end: generates link clock, Start, Stop and byte transfers
`timescale 1ns/1ps
module serial_mem_host
(
	input wire logic mclk_i,
	input wire logic reset_i,
	two_wire_if.host bus,
	input wire logic cmd_valid_i,
	input wire logic [1:0] cmd_op_i,
	input wire logic [7:0] cmd_data_i,
	input wire logic cmd_ack_i,
	output logic cmd_ready_o,
	output logic done_o,
	output logic [7:0] rx_data_o,
	output logic ack_seen_o
);
	import serial_mem_pkg::*;

	// Operations: 0 start, 1 stop, 2 write byte, 3 read byte or recover
	typedef enum {
		H_IDLE,
		H_START,
		H_STOP,
		H_BYTE,
		H_RECOVER
	} hstate_t;

	logic sda_s1_reg, sda_s2_reg;
	always_ff @(posedge mclk_i)
	begin
		sda_s1_reg <= bus.sda;
		sda_s2_reg <= sda_s1_reg;
	end

	hstate_t st_reg, st_next;
	logic [3:0] div_reg, div_next;
	logic [1:0] ph_reg, ph_next;
	logic [3:0] bit_reg, bit_next;
	logic [8:0] sh_reg, sh_next;
	logic scl_reg, scl_next;
	logic sda_reg, sda_next;
	logic rdy_reg, rdy_next;
	logic done_reg, done_next;
	logic [7:0] rx_reg, rx_next;
	logic ack_reg, ack_next;
	logic tick;
	assign tick = (div_reg == LINK_HALF_CNT - 4'h1);

	// Quarter-phase sequencer; byte data moves only while clock low, Start and Stop move it while clock high
	always_comb
	begin
		st_next = st_reg;
		div_next = tick ? 4'h0 : div_reg + 4'h1;
		ph_next = ph_reg;
		bit_next = bit_reg;
		sh_next = sh_reg;
		scl_next = scl_reg;
		sda_next = sda_reg;
		rdy_next = rdy_reg;
		done_next = 1'b0;
		rx_next = rx_reg;
		ack_next = ack_reg;
		unique case (st_reg)
			H_IDLE:
				if (cmd_valid_i && rdy_reg)
				begin
					rdy_next = 1'b0;
					ph_next = 2'h0;
					bit_next = 4'h0;
					sh_next = (cmd_op_i == 2'h3) ? {8'hFF, ~cmd_ack_i}
						: {cmd_data_i, 1'b1};
					unique case (cmd_op_i)
						2'h0: st_next = H_START;
						2'h1: st_next = H_STOP;
						2'h2: st_next = H_BYTE;
						2'h3: st_next = cmd_data_i[0] ? H_RECOVER : H_BYTE;
					endcase
				end
			H_START:
				if (tick)
				begin
					ph_next = ph_reg + 2'h1;
					unique case (ph_reg)
						2'h0: sda_next = 1'b1;
						2'h1: scl_next = 1'b1;
						2'h2: sda_next = 1'b0;
						2'h3:
						begin
							scl_next = 1'b0;
							st_next = H_IDLE;
							rdy_next = 1'b1;
							done_next = 1'b1;
						end
					endcase
				end
			H_STOP:
				if (tick)
				begin
					ph_next = ph_reg + 2'h1;
					unique case (ph_reg)
						2'h0: sda_next = 1'b0;
						2'h1: scl_next = 1'b1;
						2'h2: sda_next = 1'b1;
						2'h3:
						begin
							st_next = H_IDLE;
							rdy_next = 1'b1;
							done_next = 1'b1;
						end
					endcase
				end
			H_BYTE, H_RECOVER:
				if (tick)
				begin
					ph_next = ph_reg + 2'h1;
					unique case (ph_reg)
						2'h0: sda_next = (st_reg == H_RECOVER) | sh_reg[8];
						2'h1: scl_next = 1'b1;
						2'h2:
						begin
							sh_next = {sh_reg[7:0], 1'b1};
							if (bit_reg < BITS_PER_BYTE)
								rx_next = {rx_reg[6:0], sda_s2_reg};
							else
								ack_next = ~sda_s2_reg;
						end
						2'h3:
						begin
							scl_next = 1'b0;
							bit_next = bit_reg + 4'h1;
							// Recovery ends when data reads high or after nine clocks
							if ((st_reg == H_RECOVER && (sda_s2_reg ||
								bit_reg == RECOVERY_CLOCKS - 4'h1)) ||
								(st_reg == H_BYTE && bit_reg == BITS_PER_BYTE))
							begin
								st_next = H_IDLE;
								rdy_next = 1'b1;
								done_next = 1'b1;
							end
						end
					endcase
				end
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			st_reg <= H_IDLE;
			div_reg <= 4'h0;
			ph_reg <= 2'h0;
			bit_reg <= 4'h0;
			sh_reg <= 9'h1FF;
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			rdy_reg <= 1'b1;
			done_reg <= 1'b0;
			rx_reg <= 8'h00;
			ack_reg <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			div_reg <= div_next;
			ph_reg <= ph_next;
			bit_reg <= bit_next;
			sh_reg <= sh_next;
			scl_reg <= scl_next;
			sda_reg <= sda_next;
			rdy_reg <= rdy_next;
			done_reg <= done_next;
			rx_reg <= rx_next;
			ack_reg <= ack_next;
		end
	end

	// Open-drain drive: pull low only
	assign bus.scl_o = 1'b0;
	assign bus.scl_oe = ~scl_reg;
	assign bus.sda_host_o = 1'b0;
	assign bus.sda_host_oe = ~sda_reg;
	assign cmd_ready_o = rdy_reg;
	assign done_o = done_reg;
	assign rx_data_o = rx_reg;
	assign ack_seen_o = ack_reg;
endmodule

// ===== tb/two_wire_sva.sv
// Concurrent checks on the two-wire link between host and memory client
`timescale 1ns/1ps
module two_wire_sva
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_host_o,
	input wire logic sda_host_oe,
	input wire logic sda_dev_o,
	input wire logic sda_dev_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);

	////////////////////////////////////////////////////////////////////////
	// Bus conditions: data moving while the clock is high, and a clock rise within 16 cycles
	sequence s_start;
		$fell(sda) && scl;
	endsequence
	sequence s_stop;
		$rose(sda) && scl;
	endsequence
	sequence s_scl_rise;
		##[1:16] $rose(scl);
	endsequence

	////////////////////////////////////////////////////////////////////////
	// Pins may only pull low; a driven one would fight the pull-up
	property p_dev_open_drain;
		sda_dev_oe |-> !sda_dev_o;
	endproperty
	property p_host_open_drain;
		(scl_oe || sda_host_oe) |-> !(scl_oe && scl_o)
			&& !(sda_host_oe && sda_host_o);
	endproperty
	// Client data only moves in the clock low phase
	property p_dev_change_low;
		$changed(sda_dev_oe) |-> !scl;
	endproperty
	// A pull set up in the low phase lasts until the clock rises
	property p_ack_setup;
		$rose(sda_dev_oe) |-> sda_dev_oe throughout s_scl_rise;
	endproperty
	property p_ack_hold;
		sda_dev_oe && $rose(scl) |-> sda_dev_oe[*4];
	endproperty
	// One bit per pulse: high phase of bounded length
	property p_scl_high;
		$rose(scl) |-> scl[*4] ##[0:16] (!scl || $rose(sda));
	endproperty
	property p_start_clock;
		s_start |-> ##[1:16] !scl;
	endproperty
	// After a Stop the bus stays idle and the client lets go
	property p_stop_idle;
		s_stop |=> (scl && sda)[*4];
	endproperty
	property p_stop_release;
		s_stop |=> (!sda_dev_oe)[*8];
	endproperty

	a_dev_open_drain: assert property (p_dev_open_drain)
		else $error("client drives data high");
	a_host_open_drain: assert property (p_host_open_drain)
		else $error("host drives a line high");
	a_dev_change_low: assert property (p_dev_change_low)
		else $error("client data changed while clock high");
	a_ack_setup: assert property (p_ack_setup)
		else $error("client pull dropped before clock rise");
	a_ack_hold: assert property (p_ack_hold)
		else $error("client pull dropped in clock high phase");
	a_scl_high: assert property (p_scl_high)
		else $error("clock high phase out of range");
	a_start_clock: assert property (p_start_clock)
		else $error("no clock low after start");
	a_stop_idle: assert property (p_stop_idle)
		else $error("bus not idle after stop");
	a_stop_release: assert property (p_stop_release)
		else $error("client pulls data after stop");
endmodule

// ===== tb/tb.sv
// Testbench: host and memory client joined over the two-wire link
`timescale 1ns/1ps
module tb;
	import serial_mem_pkg::*;
	logic mclk_i, reset_i, cmd_valid_i, cmd_ack_i, write_busy_i, byte_op;
	logic [1:0] cmd_op_i;
	logic [7:0] cmd_data_i, read_data_i, rx_data_o, wr_data_o, d, h;
	logic [2:0] hw_select_i, sel;
	logic cmd_ready_o, done_o, ack_seen_o, selected_o, read_mode_o;
	logic addr_valid_o, standby_o, wr_data_valid_o, read_next_o;
	logic [15:0] word_addr_o;
	target_t target_o;
	logic [31:0] seed;
	logic [8:0] rq[$];
	logic [18:0] aq[$];
	logic [8:0] e;
	logic [18:0] a;
	int n_errors, tests_run, n_wdv, n_rn;

	two_wire_if bus();
	serial_mem_host serial_mem_host_inst (.mclk_i(mclk_i), .reset_i(reset_i),
		.bus(bus), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
		.cmd_data_i(cmd_data_i), .cmd_ack_i(cmd_ack_i),
		.cmd_ready_o(cmd_ready_o), .done_o(done_o), .rx_data_o(rx_data_o),
		.ack_seen_o(ack_seen_o));
	serial_mem_client serial_mem_client_inst (.mclk_i(mclk_i),
		.reset_i(reset_i), .bus(bus), .hw_select_i(hw_select_i),
		.write_busy_i(write_busy_i), .read_data_i(read_data_i),
		.selected_o(selected_o), .read_mode_o(read_mode_o),
		.target_o(target_o), .word_addr_o(word_addr_o),
		.addr_valid_o(addr_valid_o), .wr_data_o(wr_data_o),
		.wr_data_valid_o(wr_data_valid_o), .read_next_o(read_next_o),
		.standby_o(standby_o));
	two_wire_sva two_wire_sva_inst (.mclk_i(mclk_i), .reset_i(reset_i),
		.scl_o(bus.scl_o), .scl_oe(bus.scl_oe), .sda_host_o(bus.sda_host_o),
		.sda_host_oe(bus.sda_host_oe), .sda_dev_o(bus.sda_dev_o),
		.sda_dev_oe(bus.sda_dev_oe), .scl(bus.scl), .sda(bus.sda));

	////////////////////////////////////////////////////////////////////////
	// Free-running system clock, 25 MHz
	initial
	begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	task chk(input string what, input logic [18:0] seen, input logic [18:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task close_out();
		chk("pending", 19'(rq.size() + aq.size()), 19'h0);
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// One host command; both waits bounded so a hang ends the run
	task cmd(input logic [1:0] op, input logic [7:0] dat, input logic ack);
		int i;
		byte_op = (op == 2'h2) || (op == 2'h3 && !dat[0]);
		cmd_valid_i <= 1'b1;
		cmd_op_i <= op;
		cmd_data_i <= dat;
		cmd_ack_i <= ack;
		i = 0;
		@(posedge mclk_i);
		while (cmd_ready_o !== 1'b1 && i < 400)
		begin
			@(posedge mclk_i);
			i++;
		end
		cmd_valid_i <= 1'b0;
		@(posedge mclk_i);
		while (done_o !== 1'b1 && i < 400)
		begin
			@(posedge mclk_i);
			i++;
		end
		if (i >= 400)
		begin
			n_errors++;
			close_out();
		end
	endtask

	task start();
		cmd(2'h0, 8'h00, 1'b0);
	endtask

	task stop();
		cmd(2'h1, 8'h00, 1'b0);
		repeat (6) @(posedge mclk_i);
		chk("standby", standby_o, 1'b1);
	endtask

	// Expected acknowledge noted before the byte goes out
	task send(input logic [7:0] b, input logic ack);
		rq.push_back({1'b0, 7'h00, ack});
		cmd(2'h2, b, 1'b0);
	endtask

	task recv(input logic ack);
		rq.push_back({1'b1, read_data_i});
		cmd(2'h3, 8'h00, ack);
	endtask

	task addr(input target_t t, input logic [7:0] hi);
		logic [7:0] lo;
		lo = rnd();
		aq.push_back({t, hi, lo});
		send(hi, 1'b1);
		send(lo, 1'b1);
	endtask

	task end_test(input string s);
		$display("test %s done", s);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Watcher: each result is matched against the oldest note
	always @(negedge mclk_i)
	begin
		if (done_o === 1'b1 && byte_op)
		begin
			e = rq.pop_front();
			if (e[8])
				chk("rx_data", rx_data_o, e[7:0]);
			else
				chk("ack_seen", ack_seen_o, e[0]);
		end
		if (addr_valid_o === 1'b1)
		begin
			a = aq.pop_front();
			chk("target", target_o, a[18:16]);
			chk("word_addr", word_addr_o, a[15:0]);
		end
		// Pulses are counted here and the totals checked in the array write and read scenarios
		if (wr_data_valid_o === 1'b1)
			n_wdv++;
		if (read_next_o === 1'b1)
			n_rn++;
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		reset_i = 1'b1;
		cmd_valid_i = 1'b0;
		cmd_op_i = 2'h0;
		cmd_data_i = 8'h00;
		cmd_ack_i = 1'b0;
		write_busy_i = 1'b0;
		read_data_i = 8'h00;
		hw_select_i = 3'h0;
		seed = 32'h2754;
		n_errors = 0;
		n_wdv = 0;
		n_rn = 0;
		tests_run = 0;
		byte_op = 1'b0;
		repeat (2) @(posedge mclk_i);
		reset_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		sel = 3'(rnd());
		hw_select_i <= sel;
		// Array write with word address and one data byte
		start();
		send({TYPE_ARRAY, sel, 1'b0}, 1'b1);
		chk("selected", selected_o, 1'b1);
		chk("read_mode", read_mode_o, 1'b0);
		addr(TGT_ARRAY, rnd());
		d = rnd();
		send(d, 1'b1);
		chk("wr_data", wr_data_o, d);
		chk("wr_data_valid", 19'(n_wdv), 19'h1);
		// Array sequence closed before any register access
		stop();
		end_test("array write");
		// Register targets chosen by the first word byte
		for (int i = 0; i < 3; i++)
		begin
			h = rnd();
			start();
			send({TYPE_REGS, sel, 1'b0}, 1'b1);
			addr(i == 0 ? TGT_SECURITY : i == 1 ? TGT_CONFIG : TGT_LOCK,
				i == 2 ? {h[7:4], WA_LOCK_CODE} :
				{i == 1, h[6:4], WA_SEL_REG, h[1:0]});
			stop();
		end
		end_test("register targets");
		// Each select pin wrong, then an unknown type
		for (int i = 0; i < 4; i++)
		begin
			start();
			send(i < 3 ? {TYPE_ARRAY, sel ^ 3'(1 << i), 1'b0} :
				{4'h9, sel, 1'b0}, 1'b0);
			chk("selected", selected_o, 1'b0);
			stop();
		end
		end_test("mismatch");
		// Reserved host codes
		start();
		send({CODE_MFG_ID, 1'b0}, 1'b1);
		stop();
		start();
		send({CODE_HS_MODE, 3'(rnd())}, 1'b0);
		stop();
		end_test("host codes");
		// Internal write cycle suppresses the acknowledge
		write_busy_i <= 1'b1;
		start();
		send({TYPE_ARRAY, sel, 1'b0}, 1'b0);
		stop();
		write_busy_i <= 1'b0;
		end_test("write busy");
		// Read two bytes, the last one not acknowledged
		read_data_i <= rnd();
		start();
		send({TYPE_ARRAY, sel, 1'b1}, 1'b1);
		chk("read_mode", read_mode_o, 1'b1);
		recv(1'b1);
		recv(1'b0);
		chk("sda_dev_oe", bus.sda_dev_oe, 1'b0);
		// One byte after the address ack, one after the first host ack
		chk("read_next", 19'(n_rn), 19'h2);
		stop();
		end_test("read");
		// Recovery while the client drives zeros, then a fresh frame
		read_data_i <= 8'h00;
		start();
		send({TYPE_ARRAY, sel, 1'b1}, 1'b1);
		cmd(2'h3, 8'h01, 1'b0);
		chk("sda", bus.sda, 1'b1);
		start();
		send({TYPE_ARRAY, sel, 1'b0}, 1'b1);
		stop();
		end_test("recovery");
		close_out();
	end
endmodule
